// ===== rtl/internal_gen_active_top.sv
`timescale 1ns/1ps
// ============================================================================
// Clock enable circuit, loop filter and register slave of the clock unit.
module internal_gen_active_top
  import internal_gen_active_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     stop_mode,
  input  wire logic                     cmp_valid,
  input  wire internal_gen_active_pkg::internal_gen_active_band_e   cmp_band,
  input  wire logic                     osc_in_pin,
  output logic                          clock_gen_halt,
  output logic                          internal_gen_active,
  output logic                          external_gen_active,
  output logic                          osc_in_port_enable,
  output logic                          osc_out_port_enable,
  output logic                          internal_fast_clock,
  output logic                          base_low_clock,
  output logic                          external_clock_signal,
  output logic [3:0]                    osc_divider_field,
  output logic [7:0]                    osc_stage_field,
  output logic                          filter_settled_flag
);
  import internal_gen_active_pkg::*;

  // ==========================================================================
  // Register slave state
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              int_on_q;
  logic              ext_on_q;
  logic [2:0]        cfg_q;
  logic [MULT_W-1:0] mult_q;

  // ==========================================================================
  // Clock enable and loop filter state
  logic              halt_q;
  logic              int_act_q;
  logic              ext_act_q;
  logic              in_pe_q;
  logic              out_pe_q;
  logic              ext_clk_q;
  logic [11:0]       word_q;
  logic [11:0]       word_d;
  logic              settled_q;
  logic              fast_clk;
  logic              fast_rise;
  logic              base_clk;

  // ==========================================================================
  // Write and read decode
  wire aw_hs     = s_axi_awvalid & awready_q;
  wire w_hs      = s_axi_wvalid & wready_q;
  wire do_write  = ~awready_q & ~wready_q & ~bvalid_q;
  wire b_hs      = bvalid_q & s_axi_bready;
  wire ar_hs     = s_axi_arvalid & arready_q;
  wire r_hs      = rvalid_q & s_axi_rready;
  wire lane0     = wstrb_q[0];
  wire wr_ctrl   = do_write & lane0 & (awaddr_q[7:2] == REG_CTRL_OFS[7:2]);
  wire wr_cfg    = do_write & lane0 & (awaddr_q[7:2] == REG_CFG_OFS[7:2]);
  wire wr_mult   = do_write & lane0 & (awaddr_q[7:2] == REG_MULT_OFS[7:2]);
  wire aw_mapped = (awaddr_q[7:4] == 4'h0);
  wire ar_mapped = (s_axi_araddr[7:4] == 4'h0);
  wire permit    = cfg_q[CFG_PERMIT];
  wire run_stop  = cfg_q[CFG_RUN_STOP];
  wire xtal      = cfg_q[CFG_XTAL];

  // A one is kept only when the permit is set; a running generator may stay on.
  wire ext_on_wr = wdata_q[CTRL_EXT_ON] & (permit | ext_on_q);

  // Status view of the block's own state.
  wire [31:0] stat_word = {4'h0, word_q, 10'h000, settled_q, out_pe_q, in_pe_q,
                           ext_act_q, int_act_q, halt_q};

  // Read data selection.
  wire [31:0] rd_mux =
    (s_axi_araddr[7:2] == REG_CTRL_OFS[7:2]) ? {30'h0, ext_on_q, int_on_q} :
    (s_axi_araddr[7:2] == REG_CFG_OFS[7:2])  ? {29'h0, cfg_q} :
    (s_axi_araddr[7:2] == REG_MULT_OFS[7:2]) ? {24'h0, mult_q} :
    (s_axi_araddr[7:2] == REG_STAT_OFS[7:2]) ? stat_word : 32'h0;

  // Write channel: address and data latch independently, response after both.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= aw_mapped ? RESP_OKAY : RESP_DECERR;
      end
      if (b_hs)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read channel: one read in flight, data captured with the address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= ar_mapped ? RESP_OKAY : RESP_DECERR;
      rdata_q   <= rd_mux;
    end
    else if (r_hs)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // Software control bits; the write data is taken from the latched word.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_on_q <= 1'b0;
      ext_on_q <= 1'b0;
      cfg_q    <= 3'h0;
      mult_q   <= MULT_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        int_on_q <= wdata_q[CTRL_INT_ON];
        ext_on_q <= ext_on_wr;
      end
      if (wr_cfg)
      begin
        cfg_q <= wdata_q[2:0];
      end
      if (wr_mult)
      begin
        mult_q <= wdata_q[7:0];
      end
    end
  end

  // ==========================================================================
  // Clock enable circuit
  wire halt_d    = stop_mode & ~run_stop;
  wire int_act_d = int_on_q & ~halt_d;
  wire ext_act_d = ext_on_q & ~halt_d;

  // Port enables ignore halt so the pins stay claimed through stop.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_q    <= 1'b0;
      int_act_q <= 1'b0;
      ext_act_q <= 1'b0;
      in_pe_q   <= 1'b1;
      out_pe_q  <= 1'b1;
      ext_clk_q <= 1'b0;
    end
    else
    begin
      halt_q    <= halt_d;
      int_act_q <= int_act_d;
      ext_act_q <= ext_act_d;
      in_pe_q   <= ~ext_on_q;
      out_pe_q  <= ~(ext_on_q & xtal);
      ext_clk_q <= ext_act_q & osc_in_pin;
    end
  end

  // ==========================================================================
  // Oscillator and divider
  internal_gen_active_ring_osc u_osc
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable      (int_act_q),
    .ctrl_word   (word_q),
    .fast_clk_q  (fast_clk),
    .fast_rise_q (fast_rise)
  );

  internal_gen_active_mod_div u_div
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (int_act_q),
    .fast_clk   (fast_clk),
    .fast_rise  (fast_rise),
    .mult       (mult_q),
    .base_clk_q (base_clk)
  );

  // ==========================================================================
  // Loop filter
  wire band_ok = (cmp_band <= BAND_GT_115);
  wire apply   = cmp_valid & int_act_q & band_ok;
  wire in_five = (cmp_band == BAND_LT_100) | (cmp_band == BAND_LT_105);
  wire [11:0] corr =
    (cmp_band == BAND_LT_085) ? -CORR_32 :
    (cmp_band == BAND_LT_095) ? -CORR_8  :
    (cmp_band == BAND_LT_100) ? -CORR_1  :
    (cmp_band == BAND_LT_105) ?  CORR_1  :
    (cmp_band == BAND_LT_115) ?  CORR_8  : CORR_32;

  // One 12-bit add: stage carries ripple into the divider field and
  // the word may wrap past 9FF; plain subtraction brings it back.
  assign word_d = apply ? word_q + corr : word_q;

  // The word is frozen whenever the generator is off.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_q    <= WORD_RST;
      settled_q <= 1'b0;
    end
    else
    begin
      word_q    <= word_d;
      settled_q <= !int_act_q ? 1'b0 : (apply ? in_five : settled_q);
    end
  end

  // ==========================================================================
  // Output ports
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rresp           = rresp_q;
  assign s_axi_rdata           = rdata_q;
  assign clock_gen_halt        = halt_q;
  assign internal_gen_active   = int_act_q;
  assign external_gen_active   = ext_act_q;
  assign osc_in_port_enable    = in_pe_q;
  assign osc_out_port_enable   = out_pe_q;
  assign internal_fast_clock   = fast_clk;
  assign base_low_clock        = base_clk;
  assign external_clock_signal = ext_clk_q;
  assign osc_divider_field     = word_q[11:8];
  assign osc_stage_field       = word_q[7:0];
  assign filter_settled_flag   = settled_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_int_off_two;
    !int_act_q [*2];
  endsequence

  chk_halt_stop: assert property (halt_q == $past(stop_mode & ~run_stop))
    else $error("halt does not follow stop mode");
  chk_run_in_stop: assert property ($past(run_stop) |-> !halt_q)
    else $error("halt raised while run-in-stop set");
  chk_int_active: assert property (int_act_q == $past(int_on_q & ~halt_d))
    else $error("internal active wrong");
  chk_int_clocks_low: assert property (s_int_off_two |-> !fast_clk && !base_clk)
    else $error("clocks run while internal off");
  chk_ext_active: assert property (ext_act_q == $past(ext_on_q & ~halt_d))
    else $error("external active wrong");
  chk_ext_block: assert property (wr_ctrl && !permit && !ext_on_q |=> !ext_on_q)
    else $error("external on-bit set without permit");
  chk_ext_clk_low: assert property (!ext_act_q |=> !ext_clk_q)
    else $error("external clock while inactive");
  chk_in_port: assert property (in_pe_q == $past(~ext_on_q))
    else $error("input port enable wrong");
  chk_out_port: assert property (out_pe_q == $past(~(ext_on_q & xtal)))
    else $error("output port enable wrong");
  chk_bypass_pass: assert property (int_act_q && mult_q <= 8'h01 |=>
      base_clk == $past(fast_clk))
    else $error("bypass does not pass fast clock");
  chk_filter_step: assert property (apply |=> word_q == $past(word_q + corr))
    else $error("loop filter step wrong");
  chk_filter_hold: assert property (!apply |=> $stable(word_q))
    else $error("word changed without comparison");
  chk_settled_flag: assert property (apply |=> settled_q == $past(in_five))
    else $error("settled flag wrong");

endmodule

// ===== rtl/internal_gen_active_pkg.sv
// Summary of operation
// - Stop without run-in-stop raises halt.
// - Run-in-stop keeps clocks running, halt low.
// - Internal active is on-bit and not halt.
// - Internal inactive holds fast and base low.
// - External active is on-bit and not halt.
// - External on-bit set needs clock permit.
// - External inactive holds external clock low.
// - Input pin port enable is inverted on-bit.
// - Output pin port off for crystal mode with the external on-bit set.
// - Control word is divider over stage field.
// - Base clock is fast clock divided by N.
// - N of one or zero bypasses divider.
// - Band selects correction of 32, 8 or 1.
// - Correction adds across the whole 12-bit word.
// - Divider field A to F acts as 9.
// - Out-of-range word recovers by normal subtraction.
// - Settled flag set inside five percent band.
package internal_gen_active_pkg;

  // ==========================================================================
  // Register map and field positions
  localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  REG_CFG_OFS    = 8'h04;
  localparam logic [7:0]  REG_MULT_OFS   = 8'h08;
  localparam logic [7:0]  REG_STAT_OFS   = 8'h0c;
  localparam int          CTRL_INT_ON    = 0;
  localparam int          CTRL_EXT_ON    = 1;
  localparam int          CFG_RUN_STOP   = 0;
  localparam int          CFG_PERMIT     = 1;
  localparam int          CFG_XTAL       = 2;
  localparam int          ST_HALT        = 0;
  localparam int          ST_INT_ACT     = 1;
  localparam int          ST_EXT_ACT     = 2;
  localparam int          ST_IN_PE       = 3;
  localparam int          ST_OUT_PE      = 4;
  localparam int          ST_SETTLED     = 5;
  localparam int          ST_WORD_LSB    = 16;
  localparam int          MULT_W         = 8;
  localparam logic [7:0]  MULT_RST       = 8'h01;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  // ==========================================================================
  // Oscillator control word
  localparam int          WORD_W         = 12;
  localparam int          STAGE_W        = 8;
  localparam logic [11:0] WORD_RST       = 12'h400;
  localparam logic [3:0]  DIV_SLOWEST    = 4'h9;
  localparam logic [11:0] CORR_32        = 12'h020;
  localparam logic [11:0] CORR_8         = 12'h008;
  localparam logic [11:0] CORR_1         = 12'h001;

  // Frequency band reported by the comparator, slowest band first.
  typedef enum logic [2:0]
  {
    BAND_LT_085 = 3'b000,
    BAND_LT_095 = 3'b001,
    BAND_LT_100 = 3'b010,
    BAND_LT_105 = 3'b011,
    BAND_LT_115 = 3'b100,
    BAND_GT_115 = 3'b101
  } internal_gen_active_band_e;

  // Divider codes above 9 behave like the slowest code.
  function automatic logic [11:0] internal_gen_active_eff_word(input logic [11:0] word);
    logic [3:0] div;
    div = word[11:8];
    if (div > DIV_SLOWEST)
    begin
      div = DIV_SLOWEST;
    end
    return {div, word[7:0]};
  endfunction

endpackage

// ===== rtl/internal_gen_active_ring_osc.sv
`timescale 1ns/1ps
// ============================================================================
// Ring oscillator model: half period in aclk cycles grows with the clamped word.
module internal_gen_active_ring_osc
  import internal_gen_active_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable,
  input  wire logic [11:0] ctrl_word,
  output logic             fast_clk_q,
  output logic             fast_rise_q
);
  import internal_gen_active_pkg::*;

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        wrap;

  // The clamped word reloads the half-period counter.
  assign wrap  = (cnt_q == 12'h000);
  assign cnt_d = wrap ? internal_gen_active_eff_word(ctrl_word) : cnt_q - 12'h001;

  // Disabled oscillator sits low so no stray edge leaks out.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      cnt_q       <= 12'h000;
      fast_clk_q  <= 1'b0;
      fast_rise_q <= 1'b0;
    end
    else
    begin
      cnt_q       <= cnt_d;
      fast_clk_q  <= wrap ? ~fast_clk_q : fast_clk_q;
      fast_rise_q <= wrap & ~fast_clk_q;
    end
  end

endmodule

// ===== rtl/internal_gen_active_mod_div.sv
`timescale 1ns/1ps
// ============================================================================
// Modulo-N divider from fast clock to base clock.
module internal_gen_active_mod_div
  import internal_gen_active_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              enable,
  input  wire logic              fast_clk,
  input  wire logic              fast_rise,
  input  wire logic [MULT_W-1:0] mult,
  output logic                   base_clk_q
);
  import internal_gen_active_pkg::*;

  logic [MULT_W-1:0] cnt_q;
  logic [MULT_W-1:0] cnt_d;
  logic              bypass;

  // Count fast rising edges modulo N; high for the first half.
  assign bypass = (mult <= 8'h01);
  assign cnt_d  = (cnt_q >= mult - 8'h01) ? 8'h00 : cnt_q + 8'h01;

  // Odd N gives a slightly short high phase; frequency is exact.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      cnt_q      <= 8'h00;
      base_clk_q <= 1'b0;
    end
    else if (bypass)
    begin
      cnt_q      <= 8'h00;
      base_clk_q <= fast_clk;
    end
    else
    begin
      cnt_q      <= fast_rise ? cnt_d : cnt_q;
      base_clk_q <= (cnt_q < (mult >> 1));
    end
  end

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// Compare helper: counts every comparison and reports a mismatch at once.
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("ERROR %0t: got %h want %h", $time, (g), (e)); \
    end \
  end
// ============================================================================
// Self-checking bench for the clock generator unit.
module tb_top;
  import internal_gen_active_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [2:0]        s_axi_awprot = 3'h0;
  logic [2:0]        s_axi_arprot = 3'h0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic              stop_mode = 1'b0;
  logic              cmp_valid = 1'b0;
  logic              osc_in_pin = 1'b0;
  logic              pin_q = 1'b0;
  internal_gen_active_band_e       cmp_band = BAND_LT_085;
  logic              clock_gen_halt, internal_gen_active, external_gen_active;
  logic              osc_in_port_enable, osc_out_port_enable, filter_settled_flag;
  logic              internal_fast_clock, base_low_clock, external_clock_signal;
  logic [3:0]        osc_divider_field;
  logic [7:0]        osc_stage_field;
  int                bad_count = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                fr, br, hi, hp, nm;
  logic [33:0]       exp_r[$];
  logic [1:0]        exp_b[$];
  logic [33:0]       er;
  logic [1:0]        eb;
  logic [11:0]       ew;
  logic              es;
  logic [11:0]       corr [8];

  internal_gen_active_top uut (.*);

  // ==========================================================================
  // Clock and a random level on the external clock pin.
  always #4 aclk = ~aclk;

  // The pin level the design sampled one edge ago is kept for the clock check.
  always @(posedge aclk)
  begin
    osc_in_pin <= 1'($urandom);
    pin_q      <= osc_in_pin;
  end

  // ==========================================================================
  // Result watcher: the oldest note is compared when a response completes.
  // An unexpected response pops nothing and compares against unknown, so it fails.
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      er = (exp_r.size() > 0) ? exp_r.pop_front() : 'x;
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      eb = (exp_b.size() > 0) ? exp_b.pop_front() : 'x;
      `CHK(s_axi_bresp, eb)
    end
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================================================
  // Bus and stimulus tasks.
  task automatic close_out();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awprot  <= 3'($urandom);
    s_axi_wdata   <= d;
    s_axi_wstrb   <= {3'($urandom), 1'b1};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arprot  <= 3'($urandom);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Separate one-cycle comparison results, then one idle cycle.
  task automatic pulse(input logic [2:0] b, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      cmp_valid <= 1'b1;
      cmp_band  <= internal_gen_active_band_e'(b);
      @(posedge aclk);
      cmp_valid <= 1'b0;
    end
    @(posedge aclk);
  endtask

  // Counts rising edges of the fast and base clocks and cycles with any clock high.
  task automatic watch(input int n, output int f, output int b, output int h);
    logic pf;
    logic pb;
    f = 0;
    b = 0;
    h = 0;
    pf = internal_fast_clock;
    pb = base_low_clock;
    repeat (n)
    begin
      @(posedge aclk);
      f += int'(internal_fast_clock & ~pf);
      b += int'(base_low_clock & ~pb);
      h += int'(internal_fast_clock | base_low_clock | external_clock_signal);
      pf = internal_fast_clock;
      pb = base_low_clock;
    end
  endtask

  // ==========================================================================
  // Main sequence.
  initial
  begin
    void'($urandom(49809));
    corr = '{-CORR_32, -CORR_8, -CORR_1, CORR_1, CORR_8, CORR_32, 12'h000, 12'h000};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, an unmapped place and the permit gate on the external on-bit.
    rd(REG_CTRL_OFS, {RESP_OKAY, 32'h0});
    rd(REG_MULT_OFS, {RESP_OKAY, 24'h0, MULT_RST});
    rd(REG_STAT_OFS, {RESP_OKAY, 4'h0, WORD_RST, 16'h0018});
    rd(8'h40, {RESP_DECERR, 32'h0});
    wr(8'h40, 32'h3, RESP_DECERR);
    wr(REG_CTRL_OFS, 32'h3, RESP_OKAY);
    rd(REG_CTRL_OFS, {RESP_OKAY, 32'h1});
    wr(REG_CFG_OFS, 32'h2, RESP_OKAY);
    wr(REG_CTRL_OFS, 32'h3, RESP_OKAY);
    rd(REG_CTRL_OFS, {RESP_OKAY, 32'h3});
    settle(2);
    `CHK(internal_gen_active, 1'b1)
    `CHK(external_gen_active, 1'b1)
    `CHK(osc_in_port_enable, 1'b0)
    `CHK(osc_out_port_enable, 1'b1)
    wr(REG_CFG_OFS, 32'h6, RESP_OKAY);
    settle(2);
    `CHK(osc_out_port_enable, 1'b0)
    // While active the external clock follows the pin.
    repeat (8)
    begin
      settle(1);
      `CHK(external_clock_signal, pin_q)
    end
    // Every band, including the two unused codes.
    ew = WORD_RST;
    es = 1'b0;
    for (int b = 0; b < 8; b++)
    begin
      pulse(3'(b), 1);
      ew = ew + corr[b];
      if (b < 6)
        es = (b == 2 || b == 3);
      `CHK({osc_divider_field, osc_stage_field}, ew)
      `CHK(filter_settled_flag, es)
    end
    // Borrow across the stage field down to zero, then past it.
    pulse(3'd0, 32);
    `CHK({osc_divider_field, osc_stage_field}, 12'h000)
    pulse(3'd0, 1);
    `CHK({osc_divider_field, osc_stage_field}, 12'hfe0)
    rd(REG_STAT_OFS, {RESP_OKAY, 4'h0, 12'hfe0, 16'h0006});
    // A divider code above 9 must give the half period of code 9.
    hi = int'(internal_fast_clock);
    do
      @(posedge aclk);
    while (int'(internal_fast_clock) == hi);
    hi = int'(internal_fast_clock);
    hp = 0;
    do
    begin
      @(posedge aclk);
      hp++;
    end while (int'(internal_fast_clock) == hi);
    `CHK(hp, int'({DIV_SLOWEST, 8'he0}) + 1)
    pulse(3'd0, 1);
    `CHK({osc_divider_field, osc_stage_field}, 12'hfc0)
    pulse(3'd5, 2);
    ew = 12'h000;
    `CHK({osc_divider_field, osc_stage_field}, ew)
    // Fastest word: let any long half period run out, then measure the divider.
    settle(2600);
    foreach (corr[i])
    begin
      if (i < 4)
      begin
        nm = i + i / 2 * 2;
        wr(REG_MULT_OFS, 32'(nm), RESP_OKAY);
        settle(20);
        watch(400, fr, br, hi);
        if (i == 0)
          `CHK(fr >= 199 && fr <= 201, 1'b1)
        if (i < 2)
          `CHK(br + 1 >= fr && br <= fr + 1, 1'b1)
        else
          `CHK(br * nm + nm >= fr && br * nm <= fr + nm, 1'b1)
      end
    end
    // Stop mode without run-in-stop halts everything; pins stay with the oscillator.
    stop_mode <= 1'b1;
    settle(4);
    `CHK(clock_gen_halt, 1'b1)
    `CHK(internal_gen_active, 1'b0)
    `CHK(external_gen_active, 1'b0)
    `CHK(osc_in_port_enable, 1'b0)
    `CHK(osc_out_port_enable, 1'b0)
    watch(40, fr, br, hi);
    `CHK(hi, 0)
    pulse(3'd5, 1);
    `CHK({osc_divider_field, osc_stage_field}, ew)
    rd(REG_STAT_OFS, {RESP_OKAY, 4'h0, ew, 16'h0001});
    wr(REG_CFG_OFS, 32'h7, RESP_OKAY);
    settle(3);
    `CHK(clock_gen_halt, 1'b0)
    `CHK(internal_gen_active, 1'b1)
    `CHK(external_gen_active, 1'b1)
    stop_mode <= 1'b0;
    settle(2);
    close_out();
  end
endmodule
